// ### sdc_core.sv
module sdc_core #(
  parameter int IC_DEPTH = 16
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic MODE_WE,
  input wire logic [sdc_pkg::MODW-1:0] MODE_WDATA,
  input wire logic [sdc_pkg::AW-1:0] TMR_PERIOD,
  input wire logic [3:0] ALU_OP,
  input wire logic ALU_FLT,
  input wire logic [sdc_pkg::RAW-1:0] ALU_DST,
  input wire logic [sdc_pkg::RAW-1:0] ALU_A,
  input wire logic [sdc_pkg::RAW-1:0] ALU_B,
  input wire logic [1:0] MUL_OP,
  input wire logic [sdc_pkg::RAW-1:0] MUL_A,
  input wire logic [sdc_pkg::RAW-1:0] MUL_B,
  input wire logic [1:0] SHF_OP,
  input wire logic [sdc_pkg::RAW-1:0] SHF_DST,
  input wire logic [sdc_pkg::RAW-1:0] SHF_SRC,
  input wire logic [sdc_pkg::SHW-1:0] SHF_AMT,
  input wire logic DM_ACC,
  input wire logic DM_WRITE,
  input wire logic [sdc_pkg::RAW-1:0] DM_REG,
  input wire logic [1:0] DM_IDX,
  input wire logic [sdc_pkg::MDW-1:0] DM_MOD,
  input wire logic PM_ACC,
  input wire logic PM_WRITE,
  input wire logic [sdc_pkg::RAW-1:0] PM_REG,
  input wire logic [1:0] PM_IDX,
  input wire logic [sdc_pkg::MDW-1:0] PM_MOD,
  input wire logic AG_WE,
  input wire logic AG_GEN,
  input wire logic [1:0] AG_IDX,
  input wire logic [sdc_pkg::AW-1:0] AG_WDATA,
  input wire logic [2:0] PX_OP,
  input wire logic [sdc_pkg::RAW-1:0] PX_REG,
  input wire logic [2:0] UBR_OP,
  input wire logic [1:0] UBR_SEL,
  input wire logic [sdc_pkg::UBW-1:0] UBR_DATA,
  input wire logic SEQ_FETCH,
  input wire logic [sdc_pkg::PCW-1:0] SEQ_ADDR,
  input wire logic [sdc_pkg::BW-1:0] DM_RDATA,
  input wire logic [sdc_pkg::BW-1:0] PM_RDATA,
  output logic [sdc_pkg::MODW-1:0] MODE_Q,
  output logic [sdc_pkg::AW-1:0] DM_ADDR,
  output logic DM_RD,
  output logic DM_WR,
  output logic [sdc_pkg::BW-1:0] DM_WDATA,
  output logic [sdc_pkg::AW-1:0] PM_ADDR,
  output logic PM_RD,
  output logic PM_WR,
  output logic [sdc_pkg::BW-1:0] PM_WDATA,
  output logic PM_IFETCH,
  output logic [sdc_pkg::IW-1:0] INSTR,
  output logic INSTR_VALID,
  output logic STALL,
  output logic [sdc_pkg::BW-1:0] PX_Q,
  output logic [sdc_pkg::UBW-1:0] UBR_Q,
  output logic UBR_TEST,
  output logic TIMER_IRQ,
  output logic TIMER_EXPIRED_PIN,
  output logic TIMER_EXPIRED_PIN_OE
);
  localparam int DW = sdc_pkg::DW;
  localparam int BW = sdc_pkg::BW;
  localparam int AW = sdc_pkg::AW;
  localparam int FXL = sdc_pkg::FXL;
  localparam int IXW = $clog2(IC_DEPTH);
  localparam int TGW = sdc_pkg::PCW - IXW;
  localparam logic [FXL-1:0] Z = '0;

  logic [sdc_pkg::MODW-1:0] mode_reg;
  logic go, simd, agb;
  logic [AW-1:0] ag_reg [sdc_pkg::NBANK][sdc_pkg::NBANK][sdc_pkg::NIDX];
  logic [AW-1:0] dm_addr_cur, pm_addr_cur;
  logic [DW-1:0] dm_rd [2];
  logic [DW-1:0] pm_rd [2];
  logic [DW-1:0] px_rd [2];
  logic dm_ld_pend_reg, dm_ld_simd_reg, pm_ld_pend_reg, pm_ld_simd_reg;
  logic [sdc_pkg::RAW-1:0] dm_ld_reg, pm_ld_reg;
  logic [BW-1:0] px_reg;
  logic [sdc_pkg::UBW-1:0] ubr_reg [sdc_pkg::NUBR];
  logic [sdc_pkg::UBW-1:0] ub_cur, ub_next;
  logic [AW-1:0] tmr_cnt_reg;
  logic tmr_expire;
  sdc_pkg::sdc_ic_state_t ic_state_reg, ic_state_next;
  logic [sdc_pkg::IW-1:0] ic_data_reg [IC_DEPTH];
  logic [TGW-1:0] ic_tag_reg [IC_DEPTH];
  logic [IC_DEPTH-1:0] ic_valid_reg;
  logic [IXW-1:0] ic_idx;
  logic conflict, hit;
  logic [sdc_pkg::PCW-1:0] fill_addr_reg;
  logic ifetch_pend_reg, ifetch_fill_reg, hit_pend_reg;
  logic [sdc_pkg::IW-1:0] hit_data_reg;

  // two lanes on a 64-bit bus in SIMD, else one 40-bit value in the low bits
  function automatic logic [BW-1:0] pack(input logic [DW-1:0] x, input logic [DW-1:0] y,
                                         input logic two);
    pack = two ? {y[DW-1:FXL], x[DW-1:FXL]} : {{(BW-DW){1'b0}}, x};
  endfunction
  function automatic logic [DW-1:0] unpack(input logic [BW-1:0] d, input logic hi,
                                           input logic two);
    if (hi) unpack = {d[BW-1:sdc_pkg::LANE1_LO], Z};
    else if (two) unpack = {d[sdc_pkg::LANE1_LO-1:0], Z};
    else unpack = d[DW-1:0];
  endfunction

  // nothing new is taken while the sequencer is held for a cache fill
  assign go = !STALL; // RULE18
  assign simd = mode_reg[sdc_pkg::M_PEY];
  assign agb = mode_reg[sdc_pkg::M_AGSEC]; // RULE11
  assign MODE_Q = mode_reg;
  assign PX_Q = px_reg;

  always_ff @(posedge CLK_SYS) begin // RULE11
    if (!RST_N) mode_reg <= sdc_pkg::MODE_RST;
    else if (go && MODE_WE) mode_reg <= MODE_WDATA;
  end

  // address generators: post-modify beats a same-cycle load of that index
  assign dm_addr_cur = ag_reg[0][agb][DM_IDX];
  assign pm_addr_cur = ag_reg[1][agb][PM_IDX];
  always_ff @(posedge CLK_SYS) begin // RULE10
    if (!RST_N) begin
      for (int g = 0; g < sdc_pkg::NBANK; g++) begin
        for (int b = 0; b < sdc_pkg::NBANK; b++) begin
          for (int i = 0; i < sdc_pkg::NIDX; i++) begin
            ag_reg[g][b][i] <= '0;
          end
        end
      end
    end else if (go) begin
      if (AG_WE) ag_reg[AG_GEN][agb][AG_IDX] <= AG_WDATA;
      if (DM_ACC) ag_reg[0][agb][DM_IDX] <= dm_addr_cur + AW'($signed(DM_MOD));
      if (PM_ACC) ag_reg[1][agb][PM_IDX] <= pm_addr_cur + AW'($signed(PM_MOD));
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : pe
      // element 0 always runs, element 1 only while SIMD is on
      sdc_pe u_pe (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .en(go && (g == 0 || simd)), // RULE1 RULE2
        .rf_bank(mode_reg[sdc_pkg::M_RFSEC]),
        .mr_bank(mode_reg[sdc_pkg::M_MRSEC]),
        .alu_op(ALU_OP),
        .alu_flt(ALU_FLT),
        .alu_dst(ALU_DST),
        .alu_a(ALU_A),
        .alu_b(ALU_B),
        .mul_op(MUL_OP),
        .mul_a(MUL_A),
        .mul_b(MUL_B),
        .shf_op(SHF_OP),
        .shf_dst(SHF_DST),
        .shf_src(SHF_SRC),
        .shf_amt(SHF_AMT),
        .ld0_we(dm_ld_pend_reg && (g == 0 || dm_ld_simd_reg)), // RULE3
        .ld0_wa(dm_ld_reg),
        .ld0_wd(unpack(DM_RDATA, g == 1, dm_ld_simd_reg)),
        .ld1_we(pm_ld_pend_reg && (g == 0 || pm_ld_simd_reg)), // RULE3
        .ld1_wa(pm_ld_reg),
        .ld1_wd(unpack(PM_RDATA, g == 1, pm_ld_simd_reg)),
        .ld2_we(go && g == 0 && PX_OP == sdc_pkg::PX_TO_REG), // RULE13
        .ld2_wa(PX_REG),
        .ld2_wd(px_reg[BW-1:sdc_pkg::PX_REG_LO]),
        .rd0_a(DM_REG),
        .rd0_d(dm_rd[g]),
        .rd1_a(PM_REG),
        .rd1_d(pm_rd[g]),
        .rd2_a(PX_REG),
        .rd2_d(px_rd[g])
      );
    end
  endgenerate

  // data bus: data only, one access per cycle alongside the program bus
  always_ff @(posedge CLK_SYS) begin // RULE14 RULE17
    if (!RST_N) begin
      DM_ADDR <= '0;
      DM_RD <= 1'b0;
      DM_WR <= 1'b0;
      DM_WDATA <= '0;
      dm_ld_pend_reg <= 1'b0;
      dm_ld_simd_reg <= 1'b0;
      dm_ld_reg <= '0;
    end else begin
      DM_RD <= go && DM_ACC && !DM_WRITE;
      DM_WR <= go && DM_ACC && DM_WRITE;
      dm_ld_pend_reg <= go && DM_ACC && !DM_WRITE;
      if (go && DM_ACC) begin
        DM_ADDR <= dm_addr_cur;
        dm_ld_reg <= DM_REG;
        dm_ld_simd_reg <= simd;
        DM_WDATA <= (PX_OP == sdc_pkg::PX_TO_DM) ? px_reg :
                    pack(dm_rd[0], dm_rd[1], simd); // RULE3 RULE13
      end
    end
  end

  // program bus: data access wins the slot, a colliding fetch uses the cache
  always_ff @(posedge CLK_SYS) begin // RULE14 RULE15
    if (!RST_N) begin
      PM_ADDR <= '0;
      PM_RD <= 1'b0;
      PM_WR <= 1'b0;
      PM_WDATA <= '0;
      PM_IFETCH <= 1'b0;
      pm_ld_pend_reg <= 1'b0;
      pm_ld_simd_reg <= 1'b0;
      pm_ld_reg <= '0;
    end else begin
      PM_RD <= 1'b0;
      PM_WR <= 1'b0;
      PM_IFETCH <= 1'b0;
      pm_ld_pend_reg <= 1'b0;
      if (ic_state_reg == sdc_pkg::IC_FILL) begin
        PM_ADDR <= {{(AW-sdc_pkg::PCW){1'b0}}, fill_addr_reg}; // RULE18
        PM_RD <= 1'b1;
        PM_IFETCH <= 1'b1;
      end else if (go && PM_ACC) begin
        PM_ADDR <= pm_addr_cur;
        PM_RD <= !PM_WRITE;
        PM_WR <= PM_WRITE;
        pm_ld_pend_reg <= !PM_WRITE;
        pm_ld_reg <= PM_REG;
        pm_ld_simd_reg <= simd;
        PM_WDATA <= (PX_OP == sdc_pkg::PX_TO_PM) ? px_reg :
                    pack(pm_rd[0], pm_rd[1], simd); // RULE3 RULE13
      end else if (go && SEQ_FETCH) begin
        PM_ADDR <= {{(AW-sdc_pkg::PCW){1'b0}}, SEQ_ADDR};
        PM_RD <= 1'b1;
        PM_IFETCH <= 1'b1;
      end
    end
  end

  // exchange register: bus halves line up with the 40-bit file at the top
  always_ff @(posedge CLK_SYS) begin // RULE13
    if (!RST_N) px_reg <= '0;
    else if (go) begin
      case (PX_OP)
        sdc_pkg::PX_FROM_PM: px_reg <= PM_RDATA;
        sdc_pkg::PX_FROM_DM: px_reg <= DM_RDATA;
        sdc_pkg::PX_FROM_REG: px_reg <= {px_rd[0], {sdc_pkg::PX_REG_LO{1'b0}}};
        default: px_reg <= px_reg;
      endcase
    end
  end

  assign ub_cur = ubr_reg[UBR_SEL];
  always_comb begin // RULE12
    ub_next = ub_cur;
    case (UBR_OP)
      sdc_pkg::UB_WRITE: ub_next = UBR_DATA;
      sdc_pkg::UB_SET: ub_next = ub_cur | UBR_DATA;
      sdc_pkg::UB_CLR: ub_next = ub_cur & ~UBR_DATA;
      sdc_pkg::UB_TGL: ub_next = ub_cur ^ UBR_DATA;
      default: ub_next = ub_cur;
    endcase
  end
  always_ff @(posedge CLK_SYS) begin // RULE12
    if (!RST_N) begin
      for (int i = 0; i < sdc_pkg::NUBR; i++) begin
        ubr_reg[i] <= '0;
      end
      UBR_Q <= '0;
      UBR_TEST <= 1'b0;
    end else if (go && UBR_OP != sdc_pkg::UB_NOP) begin
      ubr_reg[UBR_SEL] <= ub_next;
      UBR_Q <= ub_next;
      if (UBR_OP == sdc_pkg::UB_TEST) UBR_TEST <= (ub_cur & UBR_DATA) == UBR_DATA;
      if (UBR_OP == sdc_pkg::UB_XOR) UBR_TEST <= (ub_cur ^ UBR_DATA) == '0;
    end
  end

  // timer runs through stalls; a period of zero behaves as one
  assign tmr_expire = mode_reg[sdc_pkg::M_TMREN] && tmr_cnt_reg <= sdc_pkg::TMR_ONE;
  always_ff @(posedge CLK_SYS) begin // RULE7
    if (!RST_N) begin
      tmr_cnt_reg <= '0;
      TIMER_IRQ <= 1'b0;
    end else begin
      TIMER_IRQ <= tmr_expire;
      if (!mode_reg[sdc_pkg::M_TMREN] || tmr_expire) tmr_cnt_reg <= TMR_PERIOD;
      else tmr_cnt_reg <= tmr_cnt_reg - sdc_pkg::TMR_ONE;
    end
  end
  always_ff @(posedge CLK_SYS) begin // RULE8
    if (!RST_N) begin
      TIMER_EXPIRED_PIN <= 1'b0;
      TIMER_EXPIRED_PIN_OE <= 1'b0;
    end else begin
      TIMER_EXPIRED_PIN <= tmr_expire && mode_reg[sdc_pkg::M_TMRPIN];
      TIMER_EXPIRED_PIN_OE <= mode_reg[sdc_pkg::M_TMRPIN];
    end
  end

  // direct-mapped; only colliding fetches are ever written
  assign ic_idx = SEQ_ADDR[IXW-1:0];
  assign conflict = go && SEQ_FETCH && PM_ACC;
  assign hit = ic_valid_reg[ic_idx] && ic_tag_reg[ic_idx] == SEQ_ADDR[sdc_pkg::PCW-1:IXW];
  always_comb begin
    ic_state_next = ic_state_reg;
    case (ic_state_reg)
      sdc_pkg::IC_RUN: if (conflict && !hit) ic_state_next = sdc_pkg::IC_FILL; // RULE18
      sdc_pkg::IC_FILL: ic_state_next = sdc_pkg::IC_RUN;
      default: ic_state_next = sdc_pkg::IC_RUN;
    endcase
  end
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      ic_state_reg <= sdc_pkg::IC_RUN;
      STALL <= 1'b0;
      fill_addr_reg <= '0;
    end else begin
      ic_state_reg <= ic_state_next;
      STALL <= ic_state_next == sdc_pkg::IC_FILL;
      if (conflict) fill_addr_reg <= SEQ_ADDR;
    end
  end
  always_ff @(posedge CLK_SYS) begin // RULE16
    if (!RST_N) begin
      ic_valid_reg <= '0;
      for (int i = 0; i < IC_DEPTH; i++) begin
        ic_data_reg[i] <= '0;
        ic_tag_reg[i] <= '0;
      end
    end else if (ifetch_pend_reg && ifetch_fill_reg) begin
      ic_valid_reg[fill_addr_reg[IXW-1:0]] <= 1'b1;
      ic_data_reg[fill_addr_reg[IXW-1:0]] <= PM_RDATA[sdc_pkg::IW-1:0];
      ic_tag_reg[fill_addr_reg[IXW-1:0]] <= fill_addr_reg[sdc_pkg::PCW-1:IXW];
    end
  end
  // hits are delayed one cycle so they answer at the same latency as plain fetches
  always_ff @(posedge CLK_SYS) begin // RULE15
    if (!RST_N) begin
      ifetch_pend_reg <= 1'b0;
      ifetch_fill_reg <= 1'b0;
      hit_pend_reg <= 1'b0;
      hit_data_reg <= '0;
      INSTR <= '0;
      INSTR_VALID <= 1'b0;
    end else begin
      ifetch_fill_reg <= ic_state_reg == sdc_pkg::IC_FILL;
      ifetch_pend_reg <= ic_state_reg == sdc_pkg::IC_FILL || (go && SEQ_FETCH && !PM_ACC);
      hit_pend_reg <= conflict && hit;
      hit_data_reg <= ic_data_reg[ic_idx];
      INSTR_VALID <= ifetch_pend_reg || hit_pend_reg;
      if (ifetch_pend_reg) INSTR <= PM_RDATA[sdc_pkg::IW-1:0];
      else if (hit_pend_reg) INSTR <= hit_data_reg;
    end
  end
endmodule

// ### sdc_core_chk.sv
module sdc_core_chk (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic MODE_WE,
  input wire logic [sdc_pkg::MODW-1:0] MODE_WDATA,
  input wire logic [sdc_pkg::AW-1:0] TMR_PERIOD,
  input wire logic DM_ACC,
  input wire logic DM_WRITE,
  input wire logic PM_ACC,
  input wire logic SEQ_FETCH,
  input wire logic [2:0] UBR_OP,
  input wire logic [sdc_pkg::UBW-1:0] UBR_DATA,
  input wire logic [sdc_pkg::MODW-1:0] MODE_Q,
  input wire logic DM_RD,
  input wire logic DM_WR,
  input wire logic PM_IFETCH,
  input wire logic INSTR_VALID,
  input wire logic STALL,
  input wire logic [sdc_pkg::UBW-1:0] UBR_Q,
  input wire logic TIMER_IRQ,
  input wire logic TIMER_EXPIRED_PIN,
  input wire logic TIMER_EXPIRED_PIN_OE
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  // gap is only trusted after a first pulse, since the reload phase is free
  logic [31:0] gap_reg;
  logic seen_reg;
  always_ff @(posedge CLK_SYS) begin
    gap_reg <= TIMER_IRQ ? 32'h1 : gap_reg + 32'h1;
  end
  always_ff @(posedge CLK_SYS) begin
    seen_reg <= RST_N && MODE_Q[sdc_pkg::M_TMREN] && (seen_reg || TIMER_IRQ);
  end
  AST_MODE_WR: assert property (MODE_WE && !STALL |=> MODE_Q == $past(MODE_WDATA))
    else $error("mode word not loaded");
  AST_TMR_GAP: assert property (TIMER_IRQ && seen_reg |-> gap_reg == TMR_PERIOD)
    else $error("timer interval wrong");
  AST_PIN_OE: assert property (TIMER_EXPIRED_PIN |-> TIMER_EXPIRED_PIN_OE && TIMER_IRQ)
    else $error("expired pin without enable or interrupt");
  AST_DM_RD: assert property (DM_ACC && !DM_WRITE && !STALL |=> DM_RD && !DM_WR)
    else $error("data read strobe missing");
  AST_DM_WR: assert property (DM_ACC && DM_WRITE && !STALL |=> DM_WR && !DM_RD)
    else $error("data write strobe missing");
  AST_STALL_ONE: assert property (STALL |=> !STALL)
    else $error("stall longer than one cycle");
  AST_MISS: assert property ($rose(STALL) |-> ##1 PM_IFETCH ##1 INSTR_VALID)
    else $error("miss fetch sequence broken");
  AST_PLAIN: assert property (SEQ_FETCH && !PM_ACC && !STALL |=> !STALL ##1 INSTR_VALID)
    else $error("plain fetch stalled or late");
  AST_UBR_WR: assert property (UBR_OP == 3'h1 && !STALL |=> UBR_Q == $past(UBR_DATA))
    else $error("bit register write lost");
  cover property (TIMER_IRQ && seen_reg);
  cover property ($rose(STALL));
  cover property (DM_WR && MODE_Q[sdc_pkg::M_PEY]);
endmodule
bind sdc_core sdc_core_chk sdc_core_chk_i (.CLK_SYS, .RST_N, .MODE_WE, .MODE_WDATA,
  .TMR_PERIOD, .DM_ACC, .DM_WRITE, .PM_ACC, .SEQ_FETCH, .UBR_OP, .UBR_DATA, .MODE_Q,
  .DM_RD, .DM_WR, .PM_IFETCH, .INSTR_VALID, .STALL, .UBR_Q, .TIMER_IRQ,
  .TIMER_EXPIRED_PIN, .TIMER_EXPIRED_PIN_OE);

// ### sdc_mem.sv
module sdc_mem (
  input wire logic clk,
  input wire logic dm_rd,
  input wire logic [sdc_pkg::AW-1:0] dm_addr,
  input wire logic pm_rd,
  input wire logic pm_ifetch,
  input wire logic [sdc_pkg::AW-1:0] pm_addr,
  output logic [sdc_pkg::BW-1:0] dm_rdata,
  output logic [sdc_pkg::BW-1:0] pm_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [sdc_pkg::BW-1:0] dm_last_reg;
  logic [sdc_pkg::BW-1:0] pm_last_reg;
  function automatic logic [sdc_pkg::BW-1:0] word_of(input logic [31:0] a);
    return {a + 32'h10, a};
  endfunction
  // idle lines flip every cycle so a late sample never matches stale data
  assign dm_rdata = dm_rd ? word_of(dm_addr) : ~dm_last_reg;
  assign pm_rdata = (pm_rd || pm_ifetch) ? word_of(pm_addr) : ~pm_last_reg;
  always_ff @(posedge clk) begin
    dm_last_reg <= dm_rdata;
    pm_last_reg <= pm_rdata;
  end
endmodule

// ### sdc_pe.sv
module sdc_pe (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic rf_bank,
  input wire logic mr_bank,
  input wire logic [3:0] alu_op,
  input wire logic alu_flt,
  input wire logic [sdc_pkg::RAW-1:0] alu_dst,
  input wire logic [sdc_pkg::RAW-1:0] alu_a,
  input wire logic [sdc_pkg::RAW-1:0] alu_b,
  input wire logic [1:0] mul_op,
  input wire logic [sdc_pkg::RAW-1:0] mul_a,
  input wire logic [sdc_pkg::RAW-1:0] mul_b,
  input wire logic [1:0] shf_op,
  input wire logic [sdc_pkg::RAW-1:0] shf_dst,
  input wire logic [sdc_pkg::RAW-1:0] shf_src,
  input wire logic [sdc_pkg::SHW-1:0] shf_amt,
  input wire logic ld0_we,
  input wire logic [sdc_pkg::RAW-1:0] ld0_wa,
  input wire logic [sdc_pkg::DW-1:0] ld0_wd,
  input wire logic ld1_we,
  input wire logic [sdc_pkg::RAW-1:0] ld1_wa,
  input wire logic [sdc_pkg::DW-1:0] ld1_wd,
  input wire logic ld2_we,
  input wire logic [sdc_pkg::RAW-1:0] ld2_wa,
  input wire logic [sdc_pkg::DW-1:0] ld2_wd,
  input wire logic [sdc_pkg::RAW-1:0] rd0_a,
  output logic [sdc_pkg::DW-1:0] rd0_d,
  input wire logic [sdc_pkg::RAW-1:0] rd1_a,
  output logic [sdc_pkg::DW-1:0] rd1_d,
  input wire logic [sdc_pkg::RAW-1:0] rd2_a,
  output logic [sdc_pkg::DW-1:0] rd2_d
);
  localparam int DW = sdc_pkg::DW;
  localparam int FXW = sdc_pkg::FXW;
  localparam int FXL = sdc_pkg::FXL;
  localparam int MRW = sdc_pkg::MRW;
  localparam logic [FXL-1:0] Z = '0;
  // both banks in one array, bank bit on top of the address
  logic [DW-1:0] rf_reg [sdc_pkg::NBANK*sdc_pkg::NREG]; // RULE9
  logic [MRW-1:0] mr_reg [sdc_pkg::NBANK]; // RULE10
  logic [DW-1:0] a_v, b_v, ma_v, mb_v, s_v, alu_r;
  logic signed [FXW-1:0] fa, fb, fma, fmb, s;
  logic signed [2*FXW-1:0] prod;
  logic [2*FXW-1:0] rot;
  logic [FXW-1:0] sh_r;
  logic [4:0] n;
  // sign-magnitude compare serves both float widths, sign sits at the top
  function automatic logic fgt(input logic [DW-1:0] x, input logic [DW-1:0] y);
    if (x[DW-1] != y[DW-1]) fgt = !x[DW-1];
    else if (!x[DW-1]) fgt = x[DW-2:0] > y[DW-2:0];
    else fgt = x[DW-2:0] < y[DW-2:0];
  endfunction
  assign a_v = rf_reg[{rf_bank, alu_a}];
  assign b_v = rf_reg[{rf_bank, alu_b}];
  assign ma_v = rf_reg[{rf_bank, mul_a}];
  assign mb_v = rf_reg[{rf_bank, mul_b}];
  assign s_v = rf_reg[{rf_bank, shf_src}];
  assign rd0_d = rf_reg[{rf_bank, rd0_a}];
  assign rd1_d = rf_reg[{rf_bank, rd1_a}];
  assign rd2_d = rf_reg[{rf_bank, rd2_a}];
  assign fa = a_v[DW-1:FXL];
  assign fb = b_v[DW-1:FXL];
  assign fma = ma_v[DW-1:FXL];
  assign fmb = mb_v[DW-1:FXL];
  assign s = s_v[DW-1:FXL];
  assign prod = fma * fmb;
  assign n = shf_amt[sdc_pkg::SHW-1] ? 5'(-shf_amt) : shf_amt[4:0];
  assign rot = {s, s} << shf_amt[4:0];
  always_comb begin // RULE6
    alu_r = a_v;
    case (alu_op)
      sdc_pkg::ALU_ADD: alu_r = {FXW'(fa + fb), Z};
      sdc_pkg::ALU_SUB: alu_r = {FXW'(fa - fb), Z};
      sdc_pkg::ALU_AND: alu_r = a_v & b_v;
      sdc_pkg::ALU_OR: alu_r = a_v | b_v;
      sdc_pkg::ALU_XOR: alu_r = a_v ^ b_v;
      sdc_pkg::ALU_NEG: alu_r = alu_flt ? {~a_v[DW-1], a_v[DW-2:0]} : {FXW'(-fa), Z};
      sdc_pkg::ALU_ABS: alu_r = alu_flt ? {1'b0, a_v[DW-2:0]} :
                                {(fa < 0) ? FXW'(-fa) : fa, Z};
      sdc_pkg::ALU_MAX: alu_r = (alu_flt ? fgt(a_v, b_v) : fa > fb) ? a_v : b_v;
      sdc_pkg::ALU_MIN: alu_r = (alu_flt ? fgt(a_v, b_v) : fa > fb) ? b_v : a_v;
      sdc_pkg::ALU_MRD: alu_r = {mr_reg[mr_bank][FXW-1:0], Z};
      default: alu_r = a_v;
    endcase
  end
  always_comb begin
    sh_r = s;
    case (shf_op)
      sdc_pkg::SHF_LSH: sh_r = shf_amt[sdc_pkg::SHW-1] ? s >> n : s << n;
      sdc_pkg::SHF_ASH: sh_r = shf_amt[sdc_pkg::SHW-1] ? s >>> n : s << n;
      sdc_pkg::SHF_ROT: sh_r = rot[2*FXW-1:FXW];
      default: sh_r = s;
    endcase
  end
  // later writes win: bus loads override results aimed at the same register
  always_ff @(posedge clk) begin // RULE4
    if (!rst_n) begin
      for (int i = 0; i < sdc_pkg::NBANK*sdc_pkg::NREG; i++) begin
        rf_reg[i] <= '0;
      end
    end else begin
      if (en && alu_op != sdc_pkg::ALU_NOP) rf_reg[{rf_bank, alu_dst}] <= alu_r;
      if (en && shf_op != sdc_pkg::SHF_NOP) rf_reg[{rf_bank, shf_dst}] <= {sh_r, Z};
      if (ld0_we) rf_reg[{rf_bank, ld0_wa}] <= ld0_wd;
      if (ld1_we) rf_reg[{rf_bank, ld1_wa}] <= ld1_wd;
      if (ld2_we) rf_reg[{rf_bank, ld2_wa}] <= ld2_wd;
    end
  end
  always_ff @(posedge clk) begin // RULE5
    if (!rst_n) begin
      mr_reg[0] <= '0;
      mr_reg[1] <= '0;
    end else if (en) begin
      case (mul_op)
        sdc_pkg::MUL_MUL: mr_reg[mr_bank] <= {{(MRW-2*FXW){prod[2*FXW-1]}}, prod};
        sdc_pkg::MUL_MAC: mr_reg[mr_bank] <= mr_reg[mr_bank] +
                                             {{(MRW-2*FXW){prod[2*FXW-1]}}, prod};
        sdc_pkg::MUL_CLR: mr_reg[mr_bank] <= '0;
        default: mr_reg[mr_bank] <= mr_reg[mr_bank];
      endcase
    end
  end
endmodule

// ### sdc_pkg.sv
// Function
// RULE1 - first element always on, second by enable
// RULE2 - SIMD: same instruction, own data per element
// RULE3 - SIMD memory access moves two values
// RULE4 - ALU, multiplier, shifter: single cycle, parallel
// RULE5 - multifunction ALU plus multiply, in both elements
// RULE6 - single, extended float and fixed operands
// RULE7 - core timer interrupts every programmed interval
// RULE8 - timer optionally drives expired flag pin
// RULE9 - ten-port file, sixteen primary, sixteen secondary
// RULE10 - secondary data, address and multiplier registers
// RULE11 - primary after reset; secondary by mode bit
// RULE12 - four bit registers: set, clear, toggle, test, xor
// RULE13 - exchange register bridges buses and register file
// RULE14 - data bus only data; program bus both
// RULE15 - four operands plus cached instruction per cycle
// RULE16 - cache only fetches colliding with program data
// RULE17 - two 64-bit transfers every cycle
// RULE18 - uncached conflict stalls once, then fills cache
package sdc_pkg;
  localparam int DW = 40;
  localparam int FXW = 32;
  localparam int FXL = 8;
  localparam int BW = 64;
  localparam int AW = 32;
  localparam int PCW = 24;
  localparam int IW = 48;
  localparam int RAW = 4;
  localparam int NREG = 16;
  localparam int NBANK = 2;
  localparam int NUBR = 4;
  localparam int UBW = 32;
  localparam int NIDX = 4;
  localparam int MRW = 80;
  localparam int SHW = 6;
  localparam int MODW = 8;
  localparam int MDW = 8;
  localparam int PX_REG_LO = 24;
  localparam int LANE1_LO = 32;
  localparam int M_PEY = 0;
  localparam int M_RFSEC = 1;
  localparam int M_MRSEC = 2;
  localparam int M_AGSEC = 3;
  localparam int M_TMREN = 4;
  localparam int M_TMRPIN = 5;
  localparam logic [MODW-1:0] MODE_RST = 8'h00;
  localparam logic [AW-1:0] TMR_ONE = 32'h00000001;
  typedef enum logic [3:0] {
    ALU_NOP = 4'h0, ALU_PASS = 4'h1, ALU_ADD = 4'h2, ALU_SUB = 4'h3,
    ALU_AND = 4'h4, ALU_OR = 4'h5, ALU_XOR = 4'h6, ALU_NEG = 4'h7,
    ALU_ABS = 4'h8, ALU_MAX = 4'h9, ALU_MIN = 4'hA, ALU_MRD = 4'hB
  } sdc_alu_op_t;
  typedef enum logic [1:0] {
    MUL_NOP = 2'h0, MUL_MUL = 2'h1, MUL_MAC = 2'h2, MUL_CLR = 2'h3
  } sdc_mul_op_t;
  typedef enum logic [1:0] {
    SHF_NOP = 2'h0, SHF_LSH = 2'h1, SHF_ASH = 2'h2, SHF_ROT = 2'h3
  } sdc_shf_op_t;
  typedef enum logic [2:0] {
    PX_NOP = 3'h0, PX_FROM_PM = 3'h1, PX_FROM_DM = 3'h2, PX_FROM_REG = 3'h3,
    PX_TO_REG = 3'h4, PX_TO_DM = 3'h5, PX_TO_PM = 3'h6
  } sdc_px_op_t;
  typedef enum logic [2:0] {
    UB_NOP = 3'h0, UB_WRITE = 3'h1, UB_SET = 3'h2, UB_CLR = 3'h3,
    UB_TGL = 3'h4, UB_TEST = 3'h5, UB_XOR = 3'h6
  } sdc_ub_op_t;
  typedef enum logic {IC_RUN = 1'b0, IC_FILL = 1'b1} sdc_ic_state_t;
endpackage

// ### tb_sdc_core.sv
module tb_sdc_core;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [2:0] op; logic [31:0] d; logic [31:0] q; logic t; logic cq;} sdc_row_t;
  logic CLK_SYS = 0, RST_N = 0, MODE_WE = 0, ALU_FLT = 0, DM_ACC = 0, DM_WRITE = 0, PM_ACC = 0;
  logic PM_WRITE = 0, AG_WE = 0, AG_GEN = 0, SEQ_FETCH = 0;
  logic [7:0] MODE_WDATA = 0, DM_MOD = 8'h01, PM_MOD = 8'h01;
  logic [31:0] TMR_PERIOD = 32'h5, AG_WDATA = 0, UBR_DATA = 0;
  logic [3:0] ALU_OP = 0, ALU_DST = 0, ALU_A = 0, ALU_B = 0, MUL_A = 0, MUL_B = 0;
  logic [3:0] SHF_DST = 0, SHF_SRC = 0, DM_REG = 0, PM_REG = 0, PX_REG = 0;
  logic [1:0] MUL_OP = 0, SHF_OP = 0, DM_IDX = 0, PM_IDX = 0, AG_IDX = 0, UBR_SEL = 2'h3;
  logic [5:0] SHF_AMT = 0;
  logic [2:0] PX_OP = 0, UBR_OP = 0;
  logic [23:0] SEQ_ADDR = 0;
  logic [7:0] MODE_Q;
  logic [31:0] DM_ADDR, PM_ADDR, UBR_Q;
  logic [63:0] DM_RDATA, PM_RDATA, DM_WDATA, PM_WDATA, PX_Q, w;
  logic [47:0] INSTR;
  logic DM_RD, DM_WR, PM_RD, PM_WR, PM_IFETCH, INSTR_VALID, STALL, UBR_TEST;
  logic TIMER_IRQ, TIMER_EXPIRED_PIN, TIMER_EXPIRED_PIN_OE;
  int bad_count = 0, check_count = 0, irq = 0, pin = 0;
  sdc_row_t rows [8] = '{'{3'h1, 32'hF0F00000, 32'hF0F00000, 1'b0, 1'b1},
    '{3'h2, 32'h0000000F, 32'hF0F0000F, 1'b0, 1'b1}, '{3'h3, 32'hF0000000, 32'h00F0000F, 1'b0, 1'b1},
    '{3'h4, 32'h00FF0000, 32'h000F000F, 1'b0, 1'b1}, '{3'h5, 32'h000F000F, 32'h0, 1'b1, 1'b0},
    '{3'h5, 32'h00100000, 32'h0, 1'b0, 1'b0}, '{3'h6, 32'h000F000F, 32'h0, 1'b1, 1'b0},
    '{3'h6, 32'h00000001, 32'h0, 1'b0, 1'b0}};
  sdc_core sdc_core_i (.*);
  sdc_mem sdc_mem_i (.clk(CLK_SYS), .dm_rd(DM_RD), .dm_addr(DM_ADDR), .pm_rd(PM_RD),
    .pm_ifetch(PM_IFETCH), .pm_addr(PM_ADDR), .dm_rdata(DM_RDATA), .pm_rdata(PM_RDATA));
  initial begin
    forever #50 CLK_SYS = ~CLK_SYS;
  end
  task automatic nx(input int n);
    repeat (n) @(negedge CLK_SYS);
  endtask
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic print_verdict;
    if (bad_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic md(input logic [7:0] v);
    MODE_WE = 1;
    MODE_WDATA = v;
    nx(1);
    MODE_WE = 0;
  endtask
  // back-to-back accesses keep the strobe up instead of dropping and raising it
  task automatic dm(input logic wr, input logic [3:0] r, input logic last);
    DM_ACC = 1;
    DM_WRITE = wr;
    DM_REG = r;
    nx(1);
    if (last) DM_ACC = 0;
  endtask
  task automatic fetch(input logic p, input logic [23:0] a);
    SEQ_FETCH = 1;
    SEQ_ADDR = a;
    PM_ACC = p;
    nx(1);
    SEQ_FETCH = 0;
    PM_ACC = 0;
  endtask
  initial begin
    nx(6);
    RST_N = 1;
    chk("mode", 0, MODE_Q);
    foreach (rows[i]) begin
      UBR_OP = rows[i].op;
      UBR_DATA = rows[i].d;
      nx(1);
      if (rows[i].cq) chk("ubr_q", rows[i].q, UBR_Q);
      else chk("ubr_test", rows[i].t, UBR_TEST);
    end
    UBR_OP = 0;
    AG_WE = 1;
    AG_WDATA = 32'h100;
    nx(1);
    AG_GEN = 1;
    AG_WDATA = 32'h200;
    nx(1);
    AG_WE = 0;
    // second element stays out of the load while off
    dm(0, 4'h2, 1);
    chk("dm_addr", 32'h100, DM_ADDR);
    md(8'h01);
    chk("mode", 8'h01, MODE_Q);
    dm(1, 4'h2, 0);
    w = {32'h110, 32'h100};
    chk("dm_wdata", {32'h0, w[39:8]}, DM_WDATA);
    dm(0, 4'h1, 0);
    dm(0, 4'h2, 1);
    nx(1);
    ALU_OP = 4'h2;
    ALU_DST = 4'h3;
    ALU_A = 4'h1;
    ALU_B = 4'h2;
    nx(1);
    ALU_OP = 0;
    dm(1, 4'h3, 1);
    chk("simd_sum", 64'h00000225_00000205, DM_WDATA);
    chk("dm_addr", 32'h104, DM_ADDR);
    PX_OP = 3'h3;
    PX_REG = 4'h3;
    nx(1);
    PX_OP = 0;
    chk("px_q", 64'h00000205_00000000, PX_Q);
    fetch(1, 24'h40);
    chk("stall", 1, STALL);
    chk("pm_rd", 1, PM_RD);
    nx(1);
    chk("ifetch_addr", 32'h40, PM_ADDR);
    nx(1);
    chk("instr", 48'h0050_00000040, INSTR);
    fetch(1, 24'h40);
    chk("hit_stall", 0, STALL);
    nx(1);
    chk("hit_valid", 1, INSTR_VALID);
    chk("hit_instr", 48'h0050_00000040, INSTR);
    // a plain fetch must not fill the cache, so the same address misses later
    fetch(0, 24'h41);
    nx(1);
    chk("plain_instr", 48'h0051_00000041, INSTR);
    fetch(1, 24'h41);
    chk("uncached", 1, STALL);
    nx(2);
    md(8'h31);
    nx(10);
    repeat (20) begin
      nx(1);
      irq += TIMER_IRQ;
      pin += TIMER_EXPIRED_PIN;
    end
    chk("irq", 4, irq);
    chk("pin", 4, pin);
    chk("pin_oe", 1, TIMER_EXPIRED_PIN_OE);
    print_verdict();
  end
  initial begin
    nx(400);
    bad_count++;
    print_verdict();
  end
endmodule
